// ==== rroh_pkg.sv ====
// Behaviour
// - Control starts and stops by host command or by event input.
// - Power-up policy codes: 0 continue, 1 stop, 2 manual; default continue.
// - The power-up policy is applied equally after a software reset.
// - Policy and control method may only be written while stopped.
// - A new policy value acts only at the next restart.
// - Restart keeps or forces run/stop and auto/manual per policy; ON/OFF restores auto.
// - Continue, prior auto, restored run: output starts from its initial value.
// - Continue, prior auto, restored stop: output starts from the stop-state value.
// - Stop or manual policy, prior auto: output starts from the stop-state value.
// - PID with prior manual keeps its previous output under every policy.
// - ON/OFF restart output is fully off or fully on, fully off under stop.
// - Control method codes: 0 two-degree PID, 1 ON/OFF; default PID.
// - ON/OFF output switches off once temperature reaches the set point.
// - Output switches on again only below set point minus heating hysteresis.
// - Direct/reverse setting chooses whether the standard ON/OFF drive rises or falls with temperature.
// - Heating and cooling hysteresis each range 0.1 to 999.9, default 1.0.
// - Standard single output always uses the heating hysteresis.
// - Cooling hysteresis matters only in heating/cooling mode.
// - Hysteresis acts only under ON/OFF control, not under PID.
// - Zero decimal places is taken as one decimal place for hysteresis.
// - Heating/cooling ON/OFF has a dead band where both outputs stay off.
package rroh_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CFG    = 8'h04;
    localparam logic [7:0] ADDR_HYST   = 8'h08;
    localparam logic [7:0] ADDR_SP     = 8'h0c;
    localparam logic [7:0] ADDR_DB     = 8'h10;
    localparam logic [7:0] ADDR_MVSTOP = 8'h14;
    localparam logic [7:0] ADDR_MV     = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;
    // Control register bits
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_STOP_BIT   = 1;
    localparam int CTRL_MANUAL_BIT = 2;
    localparam int CTRL_SRST_BIT   = 3;
    // Configuration register fields
    localparam int CFG_POL_LSB    = 0;
    localparam int CFG_METHOD_BIT = 4;
    localparam int CFG_DIRECT_BIT = 5;
    localparam int CFG_HC_BIT     = 6;
    // Status register fields
    localparam int ST_RUN_BIT    = 0;
    localparam int ST_MANUAL_BIT = 1;
    localparam int ST_HEAT_BIT   = 2;
    localparam int ST_COOL_BIT   = 3;
    localparam int ST_POL_LSB    = 4;
    localparam int ST_MV_LSB     = 16;
    // Power-up policy codes
    localparam logic [1:0] POL_CONTINUE = 2'h0;
    localparam logic [1:0] POL_STOP     = 2'h1;
    localparam logic [1:0] POL_MANUAL   = 2'h2;
    localparam logic [1:0] POL_RST      = 2'h0;
    // Control method codes
    localparam logic METHOD_PID   = 1'b0;
    localparam logic METHOD_ONOFF = 1'b1;
    localparam logic METHOD_RST   = 1'b0;
    // Hysteresis in tenths of an engineering unit
    localparam logic [15:0] HYST_MIN = 16'h0001;
    localparam logic [15:0] HYST_MAX = 16'h270f;
    localparam logic [15:0] HYST_RST = 16'h000a;
    // Output in tenths of a percent
    localparam logic [9:0] MV_FULL = 10'h3e8;
    localparam logic [9:0] MV_OFF  = 10'h000;
    localparam logic [9:0] MV_INIT = 10'h000;
    // Scale applied to process values when no decimal place is set
    localparam logic signed [20:0] DP_ZERO_SCALE = 21'sh00000a;
endpackage : rroh_pkg

// ==== rroh_onoff_cell.sv ====
`timescale 1ns/1ns
module rroh_onoff_cell
(
    // Process and threshold
    input  wire logic signed [15:0] pv_i,
    input  wire logic signed [16:0] thr_i,
    input  wire logic        [15:0] hyst_i,
    input  wire logic        [1:0]  dp_i,
    // Action and present state
    input  wire logic               direct_i,
    input  wire logic               state_i,
    // Decision
    output logic                    off_o,
    output logic                    on_o,
    output logic                    nxt_o
);
    logic signed [20:0] pv_s;
    logic signed [20:0] thr_s;
    logic signed [20:0] hy_s;

    always_comb
    begin
        pv_s  = 21'(pv_i);
        thr_s = 21'(thr_i);
        hy_s  = $signed({5'h00, hyst_i});
        // Hysteresis always carries one decimal place
        if (dp_i == 2'h0)
        begin
            pv_s  = 21'(pv_s * rroh_pkg::DP_ZERO_SCALE);
            thr_s = 21'(thr_s * rroh_pkg::DP_ZERO_SCALE);
        end
        if (direct_i)
        begin
            off_o = (pv_s <= thr_s);
            on_o  = (pv_s > 21'(thr_s + hy_s));
        end
        else
        begin
            off_o = (pv_s >= thr_s);
            on_o  = (pv_s < 21'(thr_s - hy_s));
        end
        if (off_o)
            nxt_o = 1'b0;
        else if (on_o)
            nxt_o = 1'b1;
        else
            nxt_o = state_i;
    end
endmodule : rroh_onoff_cell

// ==== rroh_restore.sv ====
`timescale 1ns/1ns
module rroh_restore
(
    // Policy and method
    input  wire logic [1:0] policy_i,
    input  wire logic       method_i,
    // State before the restart
    input  wire logic       run_i,
    input  wire logic       manual_i,
    input  wire logic [9:0] mv_i,
    input  wire logic [9:0] mv_stop_i,
    input  wire logic       heat_i,
    input  wire logic       cool_i,
    // Restored state
    output logic            run_o,
    output logic            manual_o,
    output logic [9:0]      mv_o,
    output logic            heat_o,
    output logic            cool_o
);
    always_comb
    begin
        run_o    = (policy_i == rroh_pkg::POL_STOP) ? 1'b0 : run_i;
        manual_o = (policy_i == rroh_pkg::POL_MANUAL) ? 1'b1 : manual_i;
        heat_o   = 1'b0;
        cool_o   = 1'b0;
        if (method_i == rroh_pkg::METHOD_ONOFF)
        begin
            manual_o = 1'b0;
            if (policy_i == rroh_pkg::POL_CONTINUE && run_i)
            begin
                heat_o = heat_i;
                cool_o = cool_i;
            end
            mv_o = heat_o ? rroh_pkg::MV_FULL : rroh_pkg::MV_OFF;
        end
        else if (manual_i)
            mv_o = mv_i;
        else if (policy_i == rroh_pkg::POL_CONTINUE && run_o)
            mv_o = rroh_pkg::MV_INIT;
        else
            mv_o = mv_stop_i;
    end
endmodule : rroh_restore

// ==== rroh_ctrl.sv ====
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ns
module rroh_ctrl
(
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // Wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // Event inputs
    input  wire logic               ev_start_i,
    input  wire logic               ev_stop_i,
    // Process side
    input  wire logic signed [15:0] pv_i,
    input  wire logic        [1:0]  dp_i,
    input  wire logic        [9:0]  pid_mv_i,
    // Control state and outputs
    output logic                    run_o,
    output logic                    manual_o,
    output logic      [9:0]         manipulated_variable_o,
    output logic                    heat_o,
    output logic                    cool_o
);
    typedef struct packed {
        logic        ack;
        logic [31:0] rdat;
        logic        restore;
        logic        run;
        logic        manual;
        logic [9:0]  mv;
        logic        heat;
        logic        cool;
        logic [1:0]  pol_pend;
        logic [1:0]  pol_act;
        logic        method;
        logic        direct;
        logic        hc_mode;
        logic [15:0] hyst_h;
        logic [15:0] hyst_c;
        logic [15:0] sp;
        logic [15:0] db;
        logic [9:0]  mv_stop;
    } rroh_state_t;

    rroh_state_t        st_ff;
    rroh_state_t        nxt_st;
    logic               req;
    logic               wr;
    logic [31:0]        wval;
    logic [31:0]        rval;
    logic               onoff;
    logic signed [16:0] thr_h;
    logic signed [16:0] thr_c;
    logic               h_off;
    logic               h_on;
    logic               h_nxt;
    logic               c_off;
    logic               c_on;
    logic               c_nxt;
    logic               r_run;
    logic               r_manual;
    logic [9:0]         r_mv;
    logic               r_heat;
    logic               r_cool;
    logic               cmd_start;
    logic               cmd_stop;

    function automatic logic [31:0] rroh_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                res[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return res;
    endfunction : rroh_merge

    assign onoff = (st_ff.method == rroh_pkg::METHOD_ONOFF);
    // Dead band shifts the two thresholds apart in heating/cooling mode
    assign thr_h = st_ff.hc_mode ? 17'($signed(st_ff.sp) - $signed({1'b0, st_ff.db}))
                                 : 17'($signed(st_ff.sp));
    assign thr_c = 17'($signed(st_ff.sp) + $signed({1'b0, st_ff.db}));

    rroh_onoff_cell u_heat
    (
        .pv_i     (pv_i),
        .thr_i    (thr_h),
        .hyst_i   (st_ff.hyst_h),
        .dp_i     (dp_i),
        .direct_i (st_ff.hc_mode ? 1'b0 : st_ff.direct),
        .state_i  (st_ff.heat),
        .off_o    (h_off),
        .on_o     (h_on),
        .nxt_o    (h_nxt)
    );

    rroh_onoff_cell u_cool
    (
        .pv_i     (pv_i),
        .thr_i    (thr_c),
        .hyst_i   (st_ff.hyst_c),
        .dp_i     (dp_i),
        .direct_i (1'b1),
        .state_i  (st_ff.cool),
        .off_o    (c_off),
        .on_o     (c_on),
        .nxt_o    (c_nxt)
    );

    rroh_restore u_restore
    (
        .policy_i  (st_ff.pol_pend),
        .method_i  (st_ff.method),
        .run_i     (st_ff.run),
        .manual_i  (st_ff.manual),
        .mv_i      (st_ff.mv),
        .mv_stop_i (st_ff.mv_stop),
        .heat_i    (st_ff.heat),
        .cool_i    (st_ff.cool),
        .run_o     (r_run),
        .manual_o  (r_manual),
        .mv_o      (r_mv),
        .heat_o    (r_heat),
        .cool_o    (r_cool)
    );

    assign req  = wb_cyc_i & wb_stb_i;
    // Writes land on the edge at which the master sees ack
    assign wr   = req & wb_we_i & st_ff.ack;
    assign wval = rroh_merge(rval, wb_dat_i, wb_sel_i);

    always_comb
    begin
        rval = 32'h0000_0000;
        case (wb_adr_i)
            rroh_pkg::ADDR_CTRL:
                rval[rroh_pkg::CTRL_MANUAL_BIT] = st_ff.manual;
            rroh_pkg::ADDR_CFG:
            begin
                rval[rroh_pkg::CFG_POL_LSB +: 2] = st_ff.pol_pend;
                rval[rroh_pkg::CFG_METHOD_BIT]   = st_ff.method;
                rval[rroh_pkg::CFG_DIRECT_BIT]   = st_ff.direct;
                rval[rroh_pkg::CFG_HC_BIT]       = st_ff.hc_mode;
            end
            rroh_pkg::ADDR_HYST:   rval = {st_ff.hyst_c, st_ff.hyst_h};
            rroh_pkg::ADDR_SP:     rval[15:0] = st_ff.sp;
            rroh_pkg::ADDR_DB:     rval[15:0] = st_ff.db;
            rroh_pkg::ADDR_MVSTOP: rval[9:0] = st_ff.mv_stop;
            rroh_pkg::ADDR_MV:     rval[9:0] = st_ff.mv;
            rroh_pkg::ADDR_STATUS:
            begin
                rval[rroh_pkg::ST_RUN_BIT]     = st_ff.run;
                rval[rroh_pkg::ST_MANUAL_BIT]  = st_ff.manual;
                rval[rroh_pkg::ST_HEAT_BIT]    = st_ff.heat;
                rval[rroh_pkg::ST_COOL_BIT]    = st_ff.cool;
                rval[rroh_pkg::ST_POL_LSB +: 2] = st_ff.pol_act;
                rval[rroh_pkg::ST_MV_LSB +: 10] = st_ff.mv;
            end
            default: rval = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.ack  = req & ~st_ff.ack;
        nxt_st.rdat = (req & ~st_ff.ack & ~wb_we_i) ? rval : 32'h0000_0000;
        cmd_start   = ev_start_i;
        cmd_stop    = ev_stop_i;
        if (wr && wb_adr_i == rroh_pkg::ADDR_CTRL && wb_sel_i[0])
        begin
            cmd_start = cmd_start | wb_dat_i[rroh_pkg::CTRL_START_BIT];
            cmd_stop  = cmd_stop | wb_dat_i[rroh_pkg::CTRL_STOP_BIT];
        end
        if (st_ff.restore)
        begin
            // Restart applies the policy held at this moment
            nxt_st.restore = 1'b0;
            nxt_st.pol_act = st_ff.pol_pend;
            nxt_st.run     = r_run;
            nxt_st.manual  = r_manual;
            nxt_st.mv      = r_mv;
            nxt_st.heat    = r_heat;
            nxt_st.cool    = r_cool;
        end
        else
        begin
            if (cmd_stop)
                nxt_st.run = 1'b0;
            else if (cmd_start)
                nxt_st.run = 1'b1;
            if (wr && wb_adr_i == rroh_pkg::ADDR_CTRL && wb_sel_i[0])
            begin
                nxt_st.manual  = wval[rroh_pkg::CTRL_MANUAL_BIT];
                nxt_st.restore = wval[rroh_pkg::CTRL_SRST_BIT];
            end
            if (wr && wb_adr_i == rroh_pkg::ADDR_CFG && !st_ff.run)
            begin
                if (wval[rroh_pkg::CFG_POL_LSB +: 2] <= rroh_pkg::POL_MANUAL)
                    nxt_st.pol_pend = wval[rroh_pkg::CFG_POL_LSB +: 2];
                nxt_st.method  = wval[rroh_pkg::CFG_METHOD_BIT];
                nxt_st.direct  = wval[rroh_pkg::CFG_DIRECT_BIT];
                nxt_st.hc_mode = wval[rroh_pkg::CFG_HC_BIT];
            end
            if (wr && wb_adr_i == rroh_pkg::ADDR_HYST)
            begin
                if (wval[15:0] >= rroh_pkg::HYST_MIN && wval[15:0] <= rroh_pkg::HYST_MAX)
                    nxt_st.hyst_h = wval[15:0];
                if (wval[31:16] >= rroh_pkg::HYST_MIN && wval[31:16] <= rroh_pkg::HYST_MAX)
                    nxt_st.hyst_c = wval[31:16];
            end
            if (wr && wb_adr_i == rroh_pkg::ADDR_SP)
                nxt_st.sp = wval[15:0];
            if (wr && wb_adr_i == rroh_pkg::ADDR_DB)
                nxt_st.db = wval[15:0];
            if (wr && wb_adr_i == rroh_pkg::ADDR_MVSTOP && wval[9:0] <= rroh_pkg::MV_FULL)
                nxt_st.mv_stop = wval[9:0];
            // ON/OFF switching only while running under ON/OFF
            if (st_ff.run && onoff)
            begin
                nxt_st.heat = h_nxt;
                nxt_st.cool = st_ff.hc_mode ? c_nxt : 1'b0;
            end
            else
            begin
                nxt_st.heat = 1'b0;
                nxt_st.cool = 1'b0;
            end
            if (onoff)
                nxt_st.mv = nxt_st.heat ? rroh_pkg::MV_FULL : rroh_pkg::MV_OFF;
            else if (st_ff.manual)
            begin
                if (wr && wb_adr_i == rroh_pkg::ADDR_MV && wval[9:0] <= rroh_pkg::MV_FULL)
                    nxt_st.mv = wval[9:0];
            end
            else if (st_ff.run)
                nxt_st.mv = pid_mv_i;
            else
                nxt_st.mv = st_ff.mv_stop;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff          <= '0;
            st_ff.restore  <= 1'b1;
            st_ff.pol_pend <= rroh_pkg::POL_RST;
            st_ff.pol_act  <= rroh_pkg::POL_RST;
            st_ff.method   <= rroh_pkg::METHOD_RST;
            st_ff.hyst_h   <= rroh_pkg::HYST_RST;
            st_ff.hyst_c   <= rroh_pkg::HYST_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o               = st_ff.rdat;
    assign wb_ack_o               = st_ff.ack;
    assign run_o                  = st_ff.run;
    assign manual_o               = st_ff.manual;
    assign manipulated_variable_o = st_ff.mv;
    assign heat_o                 = st_ff.heat;
    assign cool_o                 = st_ff.cool;

    a_cfg_locked: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && wb_adr_i == rroh_pkg::ADDR_CFG && st_ff.run && !st_ff.restore)
        |=> ($stable(st_ff.method) && $stable(st_ff.pol_pend)))
        else $error("config changed while running");

    a_pol_deferred: assert property (@(posedge clk_i) disable iff (rst_i)
        !$stable(st_ff.pol_act) |-> $past(st_ff.restore))
        else $error("applied policy changed outside a restart");

    a_pid_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (!onoff && !st_ff.restore) |=> (!st_ff.heat && !st_ff.cool))
        else $error("output switched under PID");

    a_heat_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.run && onoff && !st_ff.restore && h_off) |=> !st_ff.heat)
        else $error("output not off at set point");

    a_heat_on: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.run && onoff && !st_ff.restore && h_on && !h_off) |=> st_ff.heat)
        else $error("output not on below hysteresis");

    a_band_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.run && onoff && !st_ff.restore && !h_on && !h_off && !cmd_stop)
        |=> $stable(st_ff.heat))
        else $error("output changed inside hysteresis band");

    a_stop_forced: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.restore && st_ff.pol_pend == rroh_pkg::POL_STOP) |=> !st_ff.run)
        else $error("stop policy left control running");

    a_onoff_auto: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.restore && onoff) |=> (!st_ff.manual && st_ff.pol_act == $past(st_ff.pol_pend)))
        else $error("ON/OFF restart not in auto");

    a_manual_mv: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.restore && !onoff && st_ff.manual) |=> $stable(st_ff.mv))
        else $error("manual output lost on restart");

    a_cool_unused: assert property (@(posedge clk_i) disable iff (rst_i)
        (!st_ff.hc_mode && !st_ff.restore) |=> !st_ff.cool)
        else $error("cooling output active in standard mode");

    a_cool_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.run && onoff && st_ff.hc_mode && !st_ff.restore && c_off) |=> !st_ff.cool)
        else $error("cooling output not off inside dead band");

    a_cool_on: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.run && onoff && st_ff.hc_mode && !st_ff.restore && c_on && !c_off)
        |=> st_ff.cool)
        else $error("cooling output not on above its hysteresis");
endmodule : rroh_ctrl

// ==== rroh_ctrl_bench.sv ====
`timescale 1ns/1ns
module rroh_ctrl_bench;
    typedef struct packed
    {
        logic [1:0]  k;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } rroh_row_t;

    logic               clk_i    = 1'b0;
    logic               rst_i    = 1'b1;
    logic               req      = 1'b0;
    logic               we       = 1'b0;
    logic        [7:0]  adr      = 8'h00;
    logic        [31:0] wdat     = 32'h0;
    logic        [31:0] rdat;
    logic               ack;
    logic               ev_start = 1'b0;
    logic               ev_stop  = 1'b0;
    logic signed [15:0] pv       = 16'sh0096;
    logic        [1:0]  dp       = 2'h1;
    logic        [9:0]  pid_mv   = 10'h2bc;
    logic               run;
    logic               manual;
    logic        [9:0]  mv;
    logic               heat;
    logic               cool;
    logic        [31:0] q;
    int                 num_errors = 0;
    int                 tests_run  = 0;
    int                 cycles     = 0;
    rroh_row_t          rows[$];

    always #10 clk_i = ~clk_i;

    rroh_ctrl dut
    (
        .clk_i                  (clk_i),
        .rst_i                  (rst_i),
        .wb_cyc_i               (req),
        .wb_stb_i               (req),
        .wb_we_i                (we),
        .wb_adr_i               (adr),
        .wb_sel_i               (4'hf),
        .wb_dat_i               (wdat),
        .wb_dat_o               (rdat),
        .wb_ack_o               (ack),
        .ev_start_i             (ev_start),
        .ev_stop_i              (ev_stop),
        .pv_i                   (pv),
        .dp_i                   (dp),
        .pid_mv_i               (pid_mv),
        .run_o                  (run),
        .manual_o               (manual),
        .manipulated_variable_o (mv),
        .heat_o                 (heat),
        .cool_o                 (cool)
    );

    task complete_run();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task check(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : check

    // Classic single cycle; request held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        q = rdat;
        req <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask : settle

    task ev(input logic s, input logic t, input logic e);
        @(posedge clk_i);
        ev_start <= s;
        ev_stop  <= t;
        @(posedge clk_i);
        ev_start <= 1'b0;
        ev_stop  <= 1'b0;
        settle(2);
        check("run", {31'h0, e}, {31'h0, run});
    endtask : ev

    // Soft reset, then look at the state left by the restart pass itself
    task restart(input logic [31:0] d);
        wb(1'b1, rroh_pkg::ADDR_CTRL, d);
        @(negedge clk_i);
        @(negedge clk_i);
    endtask : restart

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            complete_run();
        end
    end

    initial
    begin
        // k: 0 write and read back, 1 write only, 2 pv check, 3 pv check with no decimals
        rows = '{
            '{2'h0, rroh_pkg::ADDR_HYST, 32'h00050003, 32'h00050003},
            '{2'h0, rroh_pkg::ADDR_HYST, 32'h27100004, 32'h00050004},
            '{2'h0, rroh_pkg::ADDR_HYST, 32'h00000000, 32'h00050004},
            '{2'h0, rroh_pkg::ADDR_SP, 32'h000000c8, 32'h000000c8},
            '{2'h0, rroh_pkg::ADDR_DB, 32'h00000014, 32'h00000014},
            '{2'h0, rroh_pkg::ADDR_MVSTOP, 32'h0000012c, 32'h0000012c},
            '{2'h0, rroh_pkg::ADDR_MVSTOP, 32'h000003e9, 32'h0000012c},
            '{2'h0, 8'h20, 32'hffffffff, 32'h00000000},
            '{2'h0, rroh_pkg::ADDR_CFG, 32'h00000013, 32'h00000010},
            '{2'h1, rroh_pkg::ADDR_CTRL, 32'h1, 32'h0},
            '{2'h0, rroh_pkg::ADDR_CFG, 32'h00000000, 32'h00000010},
            '{2'h2, 8'h00, 32'h96, 32'h03e80001},
            '{2'h2, 8'h00, 32'hc6, 32'h03e80001},
            '{2'h2, 8'h00, 32'hc8, 32'h00000000},
            '{2'h2, 8'h00, 32'hc5, 32'h00000000},
            '{2'h2, 8'h00, 32'hc3, 32'h03e80001},
            '{2'h2, 8'h00, 32'he6, 32'h00000000},
            '{2'h3, 8'h00, 32'hc7, 32'h03e80001},
            '{2'h1, rroh_pkg::ADDR_CTRL, 32'h2, 32'h0},
            '{2'h0, rroh_pkg::ADDR_CFG, 32'h00000030, 32'h00000030},
            '{2'h1, rroh_pkg::ADDR_CTRL, 32'h1, 32'h0},
            '{2'h2, 8'h00, 32'hd2, 32'h03e80001},
            '{2'h2, 8'h00, 32'hca, 32'h03e80001},
            '{2'h2, 8'h00, 32'hc8, 32'h00000000},
            '{2'h1, rroh_pkg::ADDR_CTRL, 32'h2, 32'h0},
            '{2'h0, rroh_pkg::ADDR_CFG, 32'h00000050, 32'h00000050},
            '{2'h1, rroh_pkg::ADDR_CTRL, 32'h1, 32'h0},
            '{2'h2, 8'h00, 32'hc8, 32'h00000000},
            '{2'h2, 8'h00, 32'he6, 32'h00000002},
            '{2'h2, 8'h00, 32'hde, 32'h00000002},
            '{2'h2, 8'h00, 32'hdc, 32'h00000000},
            '{2'h2, 8'h00, 32'haa, 32'h03e80001},
            '{2'h1, rroh_pkg::ADDR_CTRL, 32'h2, 32'h0},
            '{2'h0, rroh_pkg::ADDR_CFG, 32'h00000000, 32'h00000000},
            '{2'h1, rroh_pkg::ADDR_CTRL, 32'h1, 32'h0},
            '{2'h2, 8'h00, 32'h96, 32'h02bc0000},
            '{2'h1, rroh_pkg::ADDR_CTRL, 32'h2, 32'h0}
        };
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i])
        begin
            if (rows[i].k[1])
            begin
                @(posedge clk_i);
                dp <= {1'b0, ~rows[i].k[0]};
                pv <= rows[i].d[15:0];
                settle(3);
                check("outputs", rows[i].e, {6'h0, mv, 14'h0, cool, heat});
            end
            else
            begin
                wb(1'b1, rows[i].a, rows[i].d);
                if (rows[i].k == 2'h0)
                begin
                    wb(1'b0, rows[i].a, 32'h0);
                    check("readback", rows[i].e, q);
                end
            end
        end
        ev(1'b1, 1'b0, 1'b1);
        ev(1'b0, 1'b1, 1'b0);
        ev(1'b1, 1'b0, 1'b1);
        ev(1'b1, 1'b1, 1'b0);
        // Pending stop policy must not act before the restart
        wb(1'b1, rroh_pkg::ADDR_CFG, 32'h1);
        wb(1'b0, rroh_pkg::ADDR_STATUS, 32'h0);
        check("status", 32'h012c0000, q);
        wb(1'b1, rroh_pkg::ADDR_CTRL, 32'h1);
        wb(1'b1, rroh_pkg::ADDR_CTRL, 32'h8);
        settle(3);
        wb(1'b0, rroh_pkg::ADDR_STATUS, 32'h0);
        check("status", 32'h012c0010, q);
        // Manual policy, PID manual before restart keeps its output
        wb(1'b1, rroh_pkg::ADDR_CFG, 32'h2);
        wb(1'b1, rroh_pkg::ADDR_CTRL, 32'h4);
        wb(1'b1, rroh_pkg::ADDR_MV, 32'h1f4);
        wb(1'b1, rroh_pkg::ADDR_CTRL, 32'hc);
        settle(3);
        wb(1'b0, rroh_pkg::ADDR_STATUS, 32'h0);
        check("status", 32'h01f40022, q);
        wb(1'b1, rroh_pkg::ADDR_CTRL, 32'h0);
        wb(1'b1, rroh_pkg::ADDR_CTRL, 32'h8);
        settle(3);
        wb(1'b0, rroh_pkg::ADDR_STATUS, 32'h0);
        check("status", 32'h012c0022, q);
        // Continue policy under PID: running auto starts from the initial value
        wb(1'b1, rroh_pkg::ADDR_CFG, 32'h0);
        wb(1'b1, rroh_pkg::ADDR_CTRL, 32'h1);
        restart(32'h8);
        check("restart", {21'h0, rroh_pkg::MV_INIT, 1'b1}, {21'h0, mv, run});
        wb(1'b1, rroh_pkg::ADDR_CTRL, 32'h2);
        restart(32'h8);
        check("restart", {21'h0, 10'h12c, 1'b0}, {21'h0, mv, run});
        // ON/OFF restarts in auto; continue keeps the output, stop turns it off
        wb(1'b1, rroh_pkg::ADDR_CFG, 32'h10);
        wb(1'b1, rroh_pkg::ADDR_CTRL, 32'h5);
        restart(32'hc);
        check("restart", {19'h0, rroh_pkg::MV_FULL, 3'h3}, {19'h0, mv, manual, run, heat});
        wb(1'b1, rroh_pkg::ADDR_CTRL, 32'h2);
        wb(1'b1, rroh_pkg::ADDR_CFG, 32'h11);
        wb(1'b1, rroh_pkg::ADDR_CTRL, 32'h5);
        restart(32'hc);
        check("restart", {19'h0, rroh_pkg::MV_OFF, 3'h0}, {19'h0, mv, manual, run, heat});
        // Reset while stopped brings back the defaults
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(2);
        check("state", 32'h0, {18'h0, mv, run, manual, heat, cool});
        wb(1'b0, rroh_pkg::ADDR_CFG, 32'h0);
        check("cfg", 32'h0, q);
        wb(1'b0, rroh_pkg::ADDR_HYST, 32'h0);
        check("hyst", 32'h000a000a, q);
        wb(1'b0, rroh_pkg::ADDR_STATUS, 32'h0);
        check("status", 32'h0, q);
        complete_run();
    end
endmodule : rroh_ctrl_bench
